/* File: rtl/lgi_pkg.sv */
// Package for the link general interrupt status and mask block
package lgi_pkg;

  // Register offsets; the first flags register has no printed offset
  localparam logic [7:0] LGI_OFS_FLAGS_ONE  = 8'hc0;
  localparam logic [7:0] LGI_OFS_ENABLE_ONE = 8'hc1;
  localparam logic [7:0] LGI_OFS_FLAGS_TWO  = 8'hc2;
  localparam logic [7:0] LGI_OFS_ENABLE_TWO = 8'hc3;

  // Field positions
  localparam int LGI_BIT_SUMMARY  = 7;
  localparam int LGI_BIT_COMBINED = 0;
  localparam int LGI_BIT_LATE     = 2;
  localparam int LGI_BIT_TIMEOUT  = 1;

  // Writable masks and reset value
  localparam logic [7:0] LGI_MASK_ONE  = 8'h01;
  localparam logic [7:0] LGI_MASK_TWO  = 8'h06;
  localparam logic [7:0] LGI_RESET_VAL = 8'h00;

  // Register access request from the control word decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lgi_req_s;

  // Events raised by the link and bridge
  typedef struct packed {
    logic late_read;
    logic apb_timeout;
    logic sync_lost;
    logic combined_irq;
  } lgi_evt_s;

endpackage : lgi_pkg

/* File: rtl/lgi_sync2.sv */
// Two flip-flop synchroniser for one level input
`timescale 1ns/1ps
`default_nettype none
module lgi_sync2 (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic first;
    logic second;
  } lgi_sync_s;

  lgi_sync_s st;
  lgi_sync_s next_st;

  always_comb begin
    next_st.first  = d_i;
    next_st.second = st.first;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.second;

endmodule : lgi_sync2
`default_nettype wire

/* File: rtl/lgi_irq_regs.sv */
// General interrupt status and mask registers of the link
`timescale 1ns/1ps
`default_nettype none
// Function
// R01 - Bit 7 summarises enabled second flags
// R02 - Bit 0 shows combined controller interrupt, W1C
// R03 - Enable bit 0 gates combined interrupt
// R04 - Combined enable cleared on reset, sync loss
// R05 - Late read sets late flag bit 2
// R06 - Indirect APB read sets late flag
// R07 - APB timeout sets timeout flag bit 1
// R08 - Timeouts only as timeout setting allows
// R09 - Flags clear by write one only
// R10 - Second enables bits 2,1; late cleared
// R11 - Last-command-late raise sets late flag
// R12 - All bits reset zero, reserved read zero
module lgi_irq_regs
  import lgi_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  // Register access, same clock domain
  input  wire lgi_req_s   req_i,
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  // Events on the same clock
  input  wire logic       late_read_i,
  input  wire logic       indirect_read_i,
  input  wire logic       apb_timeout_i,
  input  wire logic       timeout_enabled_i,
  input  wire logic       sync_lost_i,
  // Combined interrupt from the controller, asynchronous
  input  wire logic       combined_irq_i,
  // Interrupt request toward the link
  output logic            irq_o
);

  typedef struct packed {
    logic       combined_flag;
    logic       combined_en;
    logic       late_flag;
    logic       timeout_flag;
    logic       late_en;
    logic       timeout_en;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
  } lgi_state_s;

  lgi_state_s st;
  lgi_state_s next_st;
  logic       combined_sync;
  logic       summary;

  // Controller interrupt is from another domain
  lgi_sync2 u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (combined_irq_i),
    .q_o       (combined_sync)
  );

  function automatic logic w1c_hit(input lgi_req_s r, input logic [7:0] ofs, input int b);
    w1c_hit = r.wr && (r.addr == ofs) && r.wdata[b];
  endfunction : w1c_hit

  // Bits that may read as one at each offset; all else is reserved
  function automatic logic [7:0] read_mask(input logic [7:0] a);
    read_mask = LGI_RESET_VAL;
    case (a)
      LGI_OFS_FLAGS_ONE: begin
        read_mask[LGI_BIT_SUMMARY]  = 1'b1;
        read_mask[LGI_BIT_COMBINED] = 1'b1;
      end
      LGI_OFS_ENABLE_ONE: begin
        read_mask = LGI_MASK_ONE;
      end
      LGI_OFS_FLAGS_TWO, LGI_OFS_ENABLE_TWO: begin
        read_mask = LGI_MASK_TWO;
      end
      default: begin
        read_mask = LGI_RESET_VAL;
      end
    endcase
  endfunction : read_mask

  assign summary = (st.late_flag && st.late_en) || (st.timeout_flag && st.timeout_en); // R01

  always_comb begin
    next_st = st;
    // Status bit latches while the line is high; a W1C clears it only once the line is low
    if (combined_sync) begin
      next_st.combined_flag = 1'b1; // R02
    end else if (w1c_hit(req_i, LGI_OFS_FLAGS_ONE, LGI_BIT_COMBINED)) begin
      next_st.combined_flag = 1'b0; // R02
    end
    if (req_i.wr && req_i.addr == LGI_OFS_ENABLE_ONE) begin
      next_st.combined_en = req_i.wdata[LGI_BIT_COMBINED]; // R03
    end
    if (req_i.wr && req_i.addr == LGI_OFS_ENABLE_TWO) begin
      next_st.late_en    = req_i.wdata[LGI_BIT_LATE]; // R10
      next_st.timeout_en = req_i.wdata[LGI_BIT_TIMEOUT]; // R10
    end
    // Sync loss clears the combined and late enables but never the flags
    if (sync_lost_i) begin
      next_st.combined_en = 1'b0; // R04
      next_st.late_en     = 1'b0; // R10
    end
    // Set wins over a same-cycle clear
    if (w1c_hit(req_i, LGI_OFS_FLAGS_TWO, LGI_BIT_LATE)) begin
      next_st.late_flag = 1'b0; // R09
    end
    if (late_read_i || indirect_read_i) begin
      next_st.late_flag = 1'b1; // R05 R06 R11
    end
    if (w1c_hit(req_i, LGI_OFS_FLAGS_TWO, LGI_BIT_TIMEOUT)) begin
      next_st.timeout_flag = 1'b0; // R09
    end
    if (apb_timeout_i && timeout_enabled_i) begin
      next_st.timeout_flag = 1'b1; // R07 R08
    end
    next_st.rvalid = req_i.rd;
    next_st.rdata  = LGI_RESET_VAL; // R12
    if (req_i.rd) begin
      case (req_i.addr)
        LGI_OFS_FLAGS_ONE: begin
          next_st.rdata[LGI_BIT_SUMMARY]  = summary; // R01
          next_st.rdata[LGI_BIT_COMBINED] = st.combined_flag; // R02
        end
        LGI_OFS_ENABLE_ONE: begin
          next_st.rdata[LGI_BIT_COMBINED] = st.combined_en;
        end
        LGI_OFS_FLAGS_TWO: begin
          next_st.rdata[LGI_BIT_LATE]    = st.late_flag;
          next_st.rdata[LGI_BIT_TIMEOUT] = st.timeout_flag;
        end
        LGI_OFS_ENABLE_TWO: begin
          next_st.rdata[LGI_BIT_LATE]    = st.late_en;
          next_st.rdata[LGI_BIT_TIMEOUT] = st.timeout_en;
        end
        default: begin
          next_st.rdata = LGI_RESET_VAL;
        end
      endcase
    end
    next_st.irq = (st.combined_flag && st.combined_en) || summary; // R03
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0; // R04 R12
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o  = st.rdata;
  assign rvalid_o = st.rvalid;
  assign irq_o    = st.irq;

  AST_SUMMARY: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R01
    req_i.rd && req_i.addr == LGI_OFS_FLAGS_ONE |=> rdata_o[LGI_BIT_SUMMARY] == $past(summary))
    else $error("summary bit wrong");
  AST_COMBINED_FOLLOWS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R02
    combined_irq_i [*3] |=> st.combined_flag)
    else $error("combined flag not set");
  AST_COMBINED_GATE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R03
    !st.combined_en && !summary |=> !irq_o)
    else $error("interrupt without enable");
  AST_SYNC_LOSS_EN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R04
    sync_lost_i |=> !st.combined_en && !st.late_en)
    else $error("enable kept on sync loss");
  AST_LATE_SET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R05
    late_read_i || indirect_read_i |=> st.late_flag)
    else $error("late flag not set");
  AST_TIMEOUT_SET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R07
    apb_timeout_i && timeout_enabled_i |=> st.timeout_flag)
    else $error("timeout flag not set");
  AST_TIMEOUT_GATED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R08
    !st.timeout_flag && !timeout_enabled_i |=> !st.timeout_flag)
    else $error("timeout flag without setting");
  AST_FLAG_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R09
    st.late_flag && !w1c_hit(req_i, LGI_OFS_FLAGS_TWO, LGI_BIT_LATE) |=> st.late_flag)
    else $error("late flag lost");
  AST_RESERVED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R12
    rvalid_o |-> (rdata_o & ~read_mask($past(req_i.addr))) == LGI_RESET_VAL)
    else $error("reserved bits set");

  // The checks below, all but AST_RESET_ZERO, watch registered state one cycle after its cause

  AST_IRQ_LATE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R01
    st.late_flag && st.late_en
    |=> irq_o)
    else $error("enabled late flag gave no interrupt");

  AST_IRQ_TIMEOUT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R10
    st.timeout_flag && st.timeout_en
    |=> irq_o)
    else $error("enabled timeout flag gave no interrupt");

  AST_IRQ_COMBINED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R03
    st.combined_flag && st.combined_en
    |=> irq_o)
    else $error("enabled combined flag gave no interrupt");

  AST_COMBINED_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R02
    req_i.rd && req_i.addr == LGI_OFS_FLAGS_ONE
    |=> rdata_o[LGI_BIT_COMBINED] == $past(st.combined_flag))
    else $error("combined flag read wrong");

  AST_COMBINED_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R02
    st.combined_flag && !w1c_hit(req_i, LGI_OFS_FLAGS_ONE, LGI_BIT_COMBINED)
    |=> st.combined_flag)
    else $error("combined flag lost");

  AST_COMBINED_W1C: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R02
    st.combined_flag && !combined_sync && w1c_hit(req_i, LGI_OFS_FLAGS_ONE, LGI_BIT_COMBINED)
    |=> !st.combined_flag)
    else $error("combined flag not cleared");

  AST_COMBINED_QUIET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R02
    !st.combined_flag && !combined_sync
    |=> !st.combined_flag)
    else $error("combined flag set without line");

  AST_COMBINED_EN_WRITE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R03
    req_i.wr && req_i.addr == LGI_OFS_ENABLE_ONE && !sync_lost_i
    |=> st.combined_en == $past(req_i.wdata[LGI_BIT_COMBINED]))
    else $error("combined enable write lost");

  AST_COMBINED_EN_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R03
    !(req_i.wr && req_i.addr == LGI_OFS_ENABLE_ONE) && !st.combined_en
    |=> !st.combined_en)
    else $error("combined enable rose without write");

  AST_ENABLE_ONE_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R03
    req_i.rd && req_i.addr == LGI_OFS_ENABLE_ONE
    |=> rdata_o[LGI_BIT_COMBINED] == $past(st.combined_en))
    else $error("combined enable read wrong");

  AST_LATE_EN_WRITE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R10
    req_i.wr && req_i.addr == LGI_OFS_ENABLE_TWO && !sync_lost_i
    |=> st.late_en == $past(req_i.wdata[LGI_BIT_LATE]))
    else $error("late enable write lost");

  AST_TIMEOUT_EN_WRITE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R10
    req_i.wr && req_i.addr == LGI_OFS_ENABLE_TWO
    |=> st.timeout_en == $past(req_i.wdata[LGI_BIT_TIMEOUT]))
    else $error("timeout enable write lost");

  AST_TIMEOUT_EN_KEPT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R10
    !(req_i.wr && req_i.addr == LGI_OFS_ENABLE_TWO)
    |=> $stable(st.timeout_en))
    else $error("timeout enable changed without write");

  AST_LATE_EN_RISE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R10
    !(req_i.wr && req_i.addr == LGI_OFS_ENABLE_TWO) && !st.late_en
    |=> !st.late_en)
    else $error("late enable rose without write");

  AST_ENABLE_TWO_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R10
    req_i.rd && req_i.addr == LGI_OFS_ENABLE_TWO
    |=> rdata_o[LGI_BIT_LATE] == $past(st.late_en)
        && rdata_o[LGI_BIT_TIMEOUT] == $past(st.timeout_en))
    else $error("second enables read wrong");

  AST_FLAGS_TWO_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R07
    req_i.rd && req_i.addr == LGI_OFS_FLAGS_TWO
    |=> rdata_o[LGI_BIT_LATE] == $past(st.late_flag)
        && rdata_o[LGI_BIT_TIMEOUT] == $past(st.timeout_flag))
    else $error("second flags read wrong");

  AST_LATE_W1C: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R09
    st.late_flag && w1c_hit(req_i, LGI_OFS_FLAGS_TWO, LGI_BIT_LATE)
    && !late_read_i && !indirect_read_i
    |=> !st.late_flag)
    else $error("late flag not cleared");

  AST_TIMEOUT_W1C: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R09
    st.timeout_flag && w1c_hit(req_i, LGI_OFS_FLAGS_TWO, LGI_BIT_TIMEOUT)
    && !(apb_timeout_i && timeout_enabled_i)
    |=> !st.timeout_flag)
    else $error("timeout flag not cleared");

  AST_TIMEOUT_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R09
    st.timeout_flag && !w1c_hit(req_i, LGI_OFS_FLAGS_TWO, LGI_BIT_TIMEOUT)
    |=> st.timeout_flag)
    else $error("timeout flag lost");

  AST_LATE_QUIET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R05
    !st.late_flag && !late_read_i && !indirect_read_i
    |=> !st.late_flag)
    else $error("late flag set without event");

  AST_INDIRECT_SET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R06
    indirect_read_i
    |=> st.late_flag)
    else $error("indirect read did not set late flag");

  AST_LAST_LATE_SET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R11
    late_read_i
    |=> st.late_flag)
    else $error("late command did not set late flag");

  AST_NO_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // R12
    !req_i.rd
    |=> !rvalid_o && rdata_o == LGI_RESET_VAL)
    else $error("read answer without request");

  AST_RESET_ZERO: assert property (@(posedge ref_clk_i) // R04
    !reset_n_i
    |-> st == '0)
    else $error("state not cleared in reset");

endmodule : lgi_irq_regs
`default_nettype wire

/* File: bench/lgi_mgr_model.sv */
// Bus manager model issuing register control words
`timescale 1ns/1ps
`default_nettype none
module lgi_mgr_model
  import lgi_pkg::*;
(
  // Clock
  input  wire logic       ref_clk_i,
  // Requests and answers
  output var lgi_req_s    req_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  initial req_o = '0;
  // Idle fields carry inverted garbage, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
    @(negedge ref_clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
    ok = rvalid_i;
    d = rdata_i;
  endtask : rd
endmodule : lgi_mgr_model
`default_nettype wire

/* File: bench/lgi_irq_regs_test.sv */
// Self-checking bench for the general interrupt registers
`timescale 1ns/1ps
`default_nettype none
module lgi_irq_regs_test
  import lgi_pkg::*;
;
  logic       ref_clk_i, reset_n_i, late, indir, tmo, tmo_en, sync_lost, comb;
  lgi_req_s   req;
  logic [7:0] rdata;
  logic       rvalid, irq;
  int         errors = 0;
  int         samples_checked = 0;

  lgi_irq_regs dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .late_read_i(late), .indirect_read_i(indir),
    .apb_timeout_i(tmo), .timeout_enabled_i(tmo_en), .sync_lost_i(sync_lost),
    .combined_irq_i(comb), .irq_o(irq));
  lgi_mgr_model mgr (.ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata),
    .rvalid_i(rvalid));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    mgr.rd(a, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask : rd_chk
  // One-cycle event pulses, one bit per event input
  localparam logic [3:0] EV_LATE  = 4'h8;
  localparam logic [3:0] EV_INDIR = 4'h4;
  localparam logic [3:0] EV_TMO   = 4'h2;
  localparam logic [3:0] EV_SYNC  = 4'h1;
  task automatic pulse(input logic [3:0] ev);
    @(negedge ref_clk_i);
    {late, indir, tmo, sync_lost} = ev;
    @(negedge ref_clk_i);
    {late, indir, tmo, sync_lost} = 4'h0;
  endtask : pulse
  task automatic complete_run;
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic test_reset;
    rd_chk(LGI_OFS_FLAGS_ONE, 8'h00);
    rd_chk(LGI_OFS_ENABLE_ONE, 8'h00);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h00);
    rd_chk(LGI_OFS_ENABLE_TWO, 8'h00);
    mgr.wr(8'h7f, 8'hff);
    rd_chk(8'h7f, 8'h00);
    mgr.wr(LGI_OFS_ENABLE_TWO, 8'hff);
    rd_chk(LGI_OFS_ENABLE_TWO, 8'h06);
  endtask : test_reset
  task automatic test_late;
    pulse(EV_LATE);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h04);
    rd_chk(LGI_OFS_FLAGS_ONE, 8'h80);
    check({7'h00, irq}, 8'h01);
    pulse(EV_SYNC);
    rd_chk(LGI_OFS_ENABLE_TWO, 8'h02);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h04);
    rd_chk(LGI_OFS_FLAGS_ONE, 8'h00);
    check({7'h00, irq}, 8'h00);
    mgr.wr(LGI_OFS_FLAGS_TWO, 8'h04);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h00);
    // Event and write-one-to-clear in the same cycle: the event must win
    fork
      mgr.wr(LGI_OFS_FLAGS_TWO, 8'h04);
      pulse(EV_LATE);
    join
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h04);
    mgr.wr(LGI_OFS_FLAGS_TWO, 8'h04);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h00);
  endtask : test_late
  task automatic test_timeout;
    pulse(EV_TMO);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h00);
    tmo_en = 1'b1;
    pulse(EV_TMO);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h02);
    rd_chk(LGI_OFS_FLAGS_ONE, 8'h80);
    pulse(EV_INDIR);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h06);
    mgr.wr(LGI_OFS_FLAGS_TWO, 8'h06);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h00);
  endtask : test_timeout
  task automatic test_combined;
    comb = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    rd_chk(LGI_OFS_FLAGS_ONE, 8'h01);
    check({7'h00, irq}, 8'h00);
    mgr.wr(LGI_OFS_ENABLE_ONE, 8'hff);
    rd_chk(LGI_OFS_ENABLE_ONE, 8'h01);
    check({7'h00, irq}, 8'h01);
    pulse(EV_SYNC);
    rd_chk(LGI_OFS_ENABLE_ONE, 8'h00);
    comb = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    mgr.wr(LGI_OFS_FLAGS_ONE, 8'h01);
    rd_chk(LGI_OFS_FLAGS_ONE, 8'h00);
  endtask : test_combined
  task automatic test_midreset;
    mgr.wr(LGI_OFS_ENABLE_ONE, 8'h01);
    mgr.wr(LGI_OFS_ENABLE_TWO, 8'h06);
    pulse(EV_LATE | EV_TMO);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h06);
    check({7'h00, irq}, 8'h01);
    @(negedge ref_clk_i);
    reset_n_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    check({7'h00, irq}, 8'h00);
    rd_chk(LGI_OFS_FLAGS_ONE, 8'h00);
    rd_chk(LGI_OFS_ENABLE_ONE, 8'h00);
    rd_chk(LGI_OFS_FLAGS_TWO, 8'h00);
    rd_chk(LGI_OFS_ENABLE_TWO, 8'h00);
  endtask : test_midreset

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {reset_n_i, late, indir, tmo, tmo_en, sync_lost, comb} = '0;
    repeat (6) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    test_reset();
    test_late();
    test_timeout();
    test_combined();
    test_midreset();
    complete_run();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule : lgi_irq_regs_test
`default_nettype wire
